// ===== core/sfab_fabric.sv
/*
  Two-layer address fabric: decodes each master's transfer by fixed
  ranges and forwards it to one of five slave ports, or answers local and reserved ones itself.
  Assumes AHB-lite masters with one transfer outstanding each, and
  slaves that keep HREADYOUT high while not selected.
*/
// Function
// - decode a flat 32-bit address space of 4 GB
// - every access is a memory transaction, no other spaces
// - two master layers joined to exactly five slave ports
// - masters reach different slaves in parallel, shared slave is arbitrated
// - core reaches all five slaves, dma only flash, sram and apb
// - dma decode reaches all flash and sram subsystem destinations
// - memory slave ports carry a per-layer master id, dma is 1
// - four sub selects into the flash subsystem
// - peripherals routed by fixed, non-relocatable address ranges
// - apb side serves ten peripheral selects
// - one transfer outstanding per master
// - reserved access pulses debug event, writes dropped, reads fixed value
// - top-of-memory fetch addresses alias onto the reset vector
// - code otp 8 KB at zero, instruction flash 32 KB
// - sram 8 KB and data otp 4 KB
// - system control, dma, sram and flash configuration regions
// - watchdog, rtc, timer and gpio 1 KB windows
// - spi, uart, two-wire and converter 1 KB windows
// - local and io interrupt controller regions
`timescale 1ns/1ps
module sfab_fabric #(
  parameter logic [31:0] RSVD_READ_VALUE = 32'h0000_0000,
  parameter logic [31:0] LOCAL_READ_VALUE = 32'h0000_0000
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // master layers, index 0 core, 1 dma
  input sfab_pkg::sfab_mreq_s MST_REQ [sfab_pkg::NUM_MASTERS],
  output sfab_pkg::sfab_mrsp_s MST_RSP [sfab_pkg::NUM_MASTERS],
  // slave ports, indexed by target
  output sfab_pkg::sfab_sreq_s SLV_REQ [sfab_pkg::NUM_SLAVES],
  input sfab_pkg::sfab_srsp_s SLV_RSP [sfab_pkg::NUM_SLAVES],
  // debug events
  output logic RESERVED_HIT,
  output logic [31:0] RESERVED_ADDR,
  output logic RESERVED_MASTER,
  output logic DMA_DENIED
);

  // ==========================================================
  // elaboration checks
  if (sfab_pkg::NUM_MASTERS != 2) begin : g_chk_masters
    $error("fabric arbiters serve exactly two masters");
  end
  if (sfab_pkg::NUM_SLAVES > 5) begin : g_chk_slaves
    $error("target encoding holds at most five slaves");
  end

  // ==========================================================
  // state
  sfab_pkg::sfab_fab_s st_reg;
  sfab_pkg::sfab_fab_s st_next;
  logic [1:0] arb_req [sfab_pkg::NUM_SLAVES];
  logic [1:0] arb_gnt [sfab_pkg::NUM_SLAVES];

  // ==========================================================
  // address decode
  function automatic sfab_pkg::sfab_dec_s decode(
    input logic [sfab_pkg::ADDR_W-1:0] a
  );
    sfab_pkg::sfab_dec_s d;
    d.tgt = sfab_pkg::TGT_RSVD;
    d.sub = sfab_pkg::SUB_NONE;
    d.addr = a;
    if (a == sfab_pkg::ALIAS_ADDR_A || a == sfab_pkg::ALIAS_ADDR_B) begin
      d.tgt = sfab_pkg::TGT_FLASH;
      d.sub = sfab_pkg::SUB_OTP_CODE;
      d.addr = sfab_pkg::RESET_VECTOR;
    end else begin
      for (int i = 0; i < sfab_pkg::NUM_REGIONS; i++) begin
        if (a >= sfab_pkg::REGION_MAP[i].base && a <= sfab_pkg::REGION_MAP[i].last) begin
          d.tgt = sfab_pkg::REGION_MAP[i].tgt;
          d.sub = sfab_pkg::REGION_MAP[i].sub;
        end
      end
    end
    return d;
  endfunction : decode

  // true while a master holds or waits for a slave
  function automatic logic on_slave(input sfab_pkg::sfab_mst_e s);
    return s == sfab_pkg::MS_ARB || s == sfab_pkg::MS_ADDR || s == sfab_pkg::MS_DATA;
  endfunction : on_slave

  // ==========================================================
  // per-slave arbitration
  // five ports
  for (genvar s = 0; s < sfab_pkg::NUM_SLAVES; s++) begin : g_slv
    always_comb begin
      for (int m = 0; m < sfab_pkg::NUM_MASTERS; m++) begin
        arb_req[s][m] = on_slave(st_reg.mst[m].state)
          && st_reg.mst[m].tgt == sfab_pkg::sfab_tgt_e'(s);
      end
    end

    sfab_arb2 u_arb (
      .CLOCK(CLOCK),
      .RST(RST),
      .REQ(arb_req[s]),
      .GNT(arb_gnt[s])
    );

    // ==========================================================
    // slave request mux
    always_comb begin
      sfab_pkg::sfab_mctx_s c;
      int o;
      c = st_reg.mst[0];
      o = 0;
      SLV_REQ[s] = '0;
      SLV_REQ[s].hready = SLV_RSP[s].hreadyout;
      if (arb_gnt[s] != 2'h0) begin
        o = arb_gnt[s][1] ? 1 : 0;
        c = st_reg.mst[o];
        SLV_REQ[s].hsel = c.state == sfab_pkg::MS_ADDR;
        SLV_REQ[s].htrans = (c.state == sfab_pkg::MS_ADDR)
          ? sfab_pkg::HTRANS_NONSEQ : sfab_pkg::HTRANS_IDLE;
        SLV_REQ[s].sub = c.sub;
        SLV_REQ[s].haddr = c.haddr;
        SLV_REQ[s].hwrite = c.hwrite;
        SLV_REQ[s].hsize = c.hsize;
        SLV_REQ[s].hwdata = c.hwdata;
        SLV_REQ[s].hmaster = sfab_pkg::MASTER_ID[o];
      end
    end
  end

  // ==========================================================
  // master layer sequencing
  always_comb begin
    sfab_pkg::sfab_mctx_s c;
    sfab_pkg::sfab_mctx_s n;
    sfab_pkg::sfab_dec_s d;
    sfab_pkg::sfab_srsp_s r;
    logic take;
    c = '0;
    n = '0;
    d = '0;
    r = '0;
    take = 1'h0;
    st_next = st_reg;
    st_next.rsvd_hit = 1'h0;
    st_next.denied = 1'h0;
    for (int m = 0; m < sfab_pkg::NUM_MASTERS; m++) begin
      c = st_reg.mst[m];
      n = c;
      r = SLV_RSP[0];
      if (c.tgt <= sfab_pkg::TGT_APB) begin
        r = SLV_RSP[c.tgt];
      end
      // new address only once the previous transfer ends
      take = (c.state == sfab_pkg::MS_IDLE || c.state == sfab_pkg::MS_DONE
        || c.state == sfab_pkg::MS_ERR2) && MST_REQ[m].htrans[1];
      // no space qualifier exists, all requests are memory space
      d = decode(MST_REQ[m].haddr);
      case (c.state)
        sfab_pkg::MS_IDLE, sfab_pkg::MS_DONE, sfab_pkg::MS_ERR2: begin
          n.state = sfab_pkg::MS_IDLE;
          if (take) begin
            n.tgt = d.tgt;
            n.sub = d.sub;
            n.haddr = d.addr;
            n.hwrite = MST_REQ[m].hwrite;
            n.hsize = MST_REQ[m].hsize;
            if (d.tgt == sfab_pkg::TGT_RSVD) begin
              n.state = sfab_pkg::MS_DONE;
              n.hrdata = RSVD_READ_VALUE;
              st_next.rsvd_hit = 1'h1;
              st_next.rsvd_addr = MST_REQ[m].haddr;
              st_next.rsvd_master = m[0];
            end else if (!sfab_pkg::MASTER_REACH[m][d.tgt]) begin
              n.state = sfab_pkg::MS_ERR1;
              st_next.denied = 1'h1;
            end else if (d.tgt == sfab_pkg::TGT_LOCAL) begin
              // interrupt controllers sit beside the core
              n.state = sfab_pkg::MS_DONE;
              n.hrdata = LOCAL_READ_VALUE;
            end else begin
              n.state = sfab_pkg::MS_ARB;
            end
          end
        end
        sfab_pkg::MS_ARB: begin
          // write data is valid through the stretched data phase
          n.hwdata = MST_REQ[m].hwdata;
          if (arb_gnt[c.tgt][m]) begin
            n.state = sfab_pkg::MS_ADDR;
          end
        end
        sfab_pkg::MS_ADDR: begin
          n.hwdata = MST_REQ[m].hwdata;
          if (r.hreadyout) begin
            n.state = sfab_pkg::MS_DATA;
          end
        end
        sfab_pkg::MS_DATA: begin
          if (r.hreadyout) begin
            n.hrdata = r.hrdata;
            // slave error restarts the two-cycle error towards the master
            n.state = (r.hresp == sfab_pkg::HRESP_ERROR)
              ? sfab_pkg::MS_ERR1 : sfab_pkg::MS_DONE;
          end
        end
        sfab_pkg::MS_ERR1: begin
          n.state = sfab_pkg::MS_ERR2;
        end
        default: begin
          n.state = sfab_pkg::MS_IDLE;
        end
      endcase
      st_next.mst[m] = n;
    end
    // dma runs last in the loop, so it wins the debug capture on a tie
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // master responses
  always_comb begin
    for (int m = 0; m < sfab_pkg::NUM_MASTERS; m++) begin
      MST_RSP[m].hrdata = st_reg.mst[m].hrdata;
      // wait states hold the master while its transfer is open
      MST_RSP[m].hready = st_reg.mst[m].state == sfab_pkg::MS_IDLE
        || st_reg.mst[m].state == sfab_pkg::MS_DONE
        || st_reg.mst[m].state == sfab_pkg::MS_ERR2;
      MST_RSP[m].hresp = (st_reg.mst[m].state == sfab_pkg::MS_ERR1
        || st_reg.mst[m].state == sfab_pkg::MS_ERR2)
        ? sfab_pkg::HRESP_ERROR : sfab_pkg::HRESP_OKAY;
    end
  end

  // ==========================================================
  // debug outputs
  // one-cycle debug pulse
  assign RESERVED_HIT = st_reg.rsvd_hit;
  assign RESERVED_ADDR = st_reg.rsvd_addr;
  assign RESERVED_MASTER = st_reg.rsvd_master;
  assign DMA_DENIED = st_reg.denied;

endmodule : sfab_fabric

// ===== core/sfab_pkg.sv
/*
  Shared constants, carriers and state types of the address fabric.
  Assumes single 200 MHz clock, AHB-lite style masters and slaves.
*/
package sfab_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_MASTERS = 2;
  localparam int NUM_SLAVES = 5;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SUB_W = 4;
  localparam int ID_W = 4;
  localparam int MST_CORE = 0;
  localparam int MST_DMA = 1;

  // ==========================================================
  // ahb encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic HRESP_ERROR = 1'h1;

  // master identifiers on the memory matrix ports; core value arbitrary
  localparam logic [ID_W-1:0] MASTER_ID [NUM_MASTERS] = '{4'h0, 4'h1};

  // ==========================================================
  // targets; values 0..4 are the slave port indices
  typedef enum logic [2:0] {
    TGT_DMA = 3'h0,
    TGT_FLASH = 3'h1,
    TGT_SRAM = 3'h2,
    TGT_SCS = 3'h3,
    TGT_APB = 3'h4,
    TGT_LOCAL = 3'h5,
    TGT_RSVD = 3'h6
  } sfab_tgt_e;

  // bit n set: master may reach target n
  localparam logic [6:0] MASTER_REACH [NUM_MASTERS] = '{7'h3F, 7'h16};

  // sub selects inside each subsystem
  localparam logic [SUB_W-1:0] SUB_FLASH_CFG = 4'h0;
  localparam logic [SUB_W-1:0] SUB_FLASH_CODE = 4'h1;
  localparam logic [SUB_W-1:0] SUB_OTP_CODE = 4'h2;
  localparam logic [SUB_W-1:0] SUB_OTP_DATA = 4'h3;
  localparam logic [SUB_W-1:0] SUB_SRAM = 4'h0;
  localparam logic [SUB_W-1:0] SUB_SRAM_CFG = 4'h1;
  localparam logic [SUB_W-1:0] SUB_WDT = 4'h0;
  localparam logic [SUB_W-1:0] SUB_RTC = 4'h1;
  localparam logic [SUB_W-1:0] SUB_TIMER = 4'h2;
  localparam logic [SUB_W-1:0] SUB_GPIO = 4'h3;
  localparam logic [SUB_W-1:0] SUB_SPI_M = 4'h4;
  localparam logic [SUB_W-1:0] SUB_SPI_S = 4'h5;
  localparam logic [SUB_W-1:0] SUB_UART_A = 4'h6;
  localparam logic [SUB_W-1:0] SUB_UART_B = 4'h7;
  localparam logic [SUB_W-1:0] SUB_TWI = 4'h8;
  localparam logic [SUB_W-1:0] SUB_ADC = 4'h9;
  localparam logic [SUB_W-1:0] SUB_LOCAL_IC = 4'h0;
  localparam logic [SUB_W-1:0] SUB_IO_IC = 4'h1;
  localparam logic [SUB_W-1:0] SUB_NONE = 4'h0;

  // top-of-memory fetch addresses folded onto the reset vector
  localparam logic [ADDR_W-1:0] ALIAS_ADDR_A = 32'hFFFF_FFF0;
  localparam logic [ADDR_W-1:0] ALIAS_ADDR_B = 32'hFFFF_FFF8;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 32'h0000_0150;

  // ==========================================================
  // fixed address map
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] last;
    sfab_tgt_e tgt;
    logic [SUB_W-1:0] sub;
  } sfab_region_s;

  localparam int NUM_REGIONS = 20;
  localparam sfab_region_s REGION_MAP [NUM_REGIONS] = '{
    '{32'hFEE0_0000, 32'hFEE0_0FFF, TGT_LOCAL, SUB_LOCAL_IC},
    '{32'hFEC0_0000, 32'hFECF_FFFF, TGT_LOCAL, SUB_IO_IC},
    '{32'hB080_0000, 32'hB080_3FFF, TGT_SCS, SUB_NONE},
    '{32'hB070_0000, 32'hB070_0FFF, TGT_DMA, SUB_NONE},
    '{32'hB040_0000, 32'hB040_03FF, TGT_SRAM, SUB_SRAM_CFG},
    '{32'hB010_0000, 32'hB010_03FF, TGT_FLASH, SUB_FLASH_CFG},
    '{32'hB000_4000, 32'hB000_43FF, TGT_APB, SUB_ADC},
    '{32'hB000_2800, 32'hB000_2BFF, TGT_APB, SUB_TWI},
    '{32'hB000_2400, 32'hB000_27FF, TGT_APB, SUB_UART_B},
    '{32'hB000_2000, 32'hB000_23FF, TGT_APB, SUB_UART_A},
    '{32'hB000_1800, 32'hB000_1BFF, TGT_APB, SUB_SPI_S},
    '{32'hB000_1000, 32'hB000_13FF, TGT_APB, SUB_SPI_M},
    '{32'hB000_0C00, 32'hB000_0FFF, TGT_APB, SUB_GPIO},
    '{32'hB000_0800, 32'hB000_0BFF, TGT_APB, SUB_TIMER},
    '{32'hB000_0400, 32'hB000_07FF, TGT_APB, SUB_RTC},
    '{32'hB000_0000, 32'hB000_03FF, TGT_APB, SUB_WDT},
    '{32'h0028_0000, 32'h0028_1FFF, TGT_SRAM, SUB_SRAM},
    '{32'h0020_0000, 32'h0020_0FFF, TGT_FLASH, SUB_OTP_DATA},
    '{32'h0018_0000, 32'h0018_7FFF, TGT_FLASH, SUB_FLASH_CODE},
    '{32'h0000_0000, 32'h0000_1FFF, TGT_FLASH, SUB_OTP_CODE}
  };

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [DATA_W-1:0] hwdata;
  } sfab_mreq_s;

  typedef struct packed {
    logic [DATA_W-1:0] hrdata;
    logic hready;
    logic hresp;
  } sfab_mrsp_s;

  typedef struct packed {
    logic hsel;
    logic [SUB_W-1:0] sub;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [DATA_W-1:0] hwdata;
    logic hready;
    logic [ID_W-1:0] hmaster;
  } sfab_sreq_s;

  typedef struct packed {
    logic [DATA_W-1:0] hrdata;
    logic hreadyout;
    logic hresp;
  } sfab_srsp_s;

  typedef struct packed {
    sfab_tgt_e tgt;
    logic [SUB_W-1:0] sub;
    logic [ADDR_W-1:0] addr;
  } sfab_dec_s;

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    MS_IDLE = 3'h0,
    MS_ARB = 3'h1,
    MS_ADDR = 3'h2,
    MS_DATA = 3'h3,
    MS_ERR1 = 3'h4,
    MS_ERR2 = 3'h5,
    MS_DONE = 3'h6
  } sfab_mst_e;

  typedef struct packed {
    sfab_mst_e state;
    sfab_tgt_e tgt;
    logic [SUB_W-1:0] sub;
    logic [ADDR_W-1:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic [DATA_W-1:0] hwdata;
    logic [DATA_W-1:0] hrdata;
  } sfab_mctx_s;

  typedef struct packed {
    sfab_mctx_s [NUM_MASTERS-1:0] mst;
    logic rsvd_hit;
    logic [ADDR_W-1:0] rsvd_addr;
    logic rsvd_master;
    logic denied;
  } sfab_fab_s;

  typedef struct packed {
    logic [NUM_MASTERS-1:0] owner;
    logic last;
  } sfab_arb_s;

endpackage : sfab_pkg

// ===== core/sfab_arb2.sv
/*
  Two-requester slave arbiter with round-robin hand-over.
  Assumes a requester holds its request for the whole transfer.
*/
`timescale 1ns/1ps
module sfab_arb2 (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // requests and one-hot grant
  input wire logic [1:0] REQ,
  output logic [1:0] GNT
);

  sfab_pkg::sfab_arb_s st_reg;
  sfab_pkg::sfab_arb_s st_next;

  // ==========================================================
  // grant selection
  always_comb begin
    st_next = st_reg;
    // the owner keeps the slave until it drops its request
    if ((st_reg.owner & REQ) == 2'h0) begin
      if (REQ == 2'h3) begin
        st_next.owner = st_reg.last ? 2'h1 : 2'h2;
      end else begin
        st_next.owner = REQ;
      end
    end
    if (st_next.owner != 2'h0) begin
      st_next.last = st_next.owner[1];
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign GNT = st_reg.owner & REQ;

endmodule : sfab_arb2

// ===== testbench/sfab_fabric_checker.sv
/*
  Port-level assertions for the two-layer address fabric.
  Assumes a bind onto sfab_fabric, one clock, asynchronous high reset.
*/
`timescale 1ns/1ps
module sfab_fabric_checker (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // master layers
  input sfab_pkg::sfab_mreq_s MST_REQ [sfab_pkg::NUM_MASTERS],
  input sfab_pkg::sfab_mrsp_s MST_RSP [sfab_pkg::NUM_MASTERS],
  // slave ports
  input sfab_pkg::sfab_sreq_s SLV_REQ [sfab_pkg::NUM_SLAVES],
  input sfab_pkg::sfab_srsp_s SLV_RSP [sfab_pkg::NUM_SLAVES],
  // debug events
  input wire logic RESERVED_HIT,
  input wire logic [31:0] RESERVED_ADDR,
  input wire logic RESERVED_MASTER,
  input wire logic DMA_DENIED
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  // ==========================================================
  // transfer accepted on a layer
  logic [1:0] take;
  assign take[0] = MST_REQ[0].htrans[1] && MST_RSP[0].hready;
  assign take[1] = MST_REQ[1].htrans[1] && MST_RSP[1].hready;

  // ==========================================================
  // slave side
  for (genvar s = 0; s < 5; s++) begin : g_slv
    a_addr_phase: assert property (
      SLV_REQ[s].hsel |-> SLV_REQ[s].htrans == sfab_pkg::HTRANS_NONSEQ ##1 !SLV_REQ[s].hsel)
      else $error("slave select is not one nonseq cycle");
  end
  a_dma_no_scs: assert property (
    !(SLV_REQ[0].hsel && SLV_REQ[0].hmaster == 4'h1)
    && !(SLV_REQ[3].hsel && SLV_REQ[3].hmaster == 4'h1))
    else $error("dma layer reached a slave outside its reach");
  a_hmaster_dma: assert property (
    take[1] && MST_REQ[1].haddr[31:16] == 16'h0028
    |-> ##[3:40] SLV_REQ[2].hsel && SLV_REQ[2].hmaster == 4'h1)
    else $error("sram port missing dma master id");
  a_alias_vector: assert property (
    take[0] && MST_REQ[0].haddr == 32'hFFFF_FFF8
    |-> ##[3:40] SLV_REQ[1].hsel && SLV_REQ[1].sub == sfab_pkg::SUB_OTP_CODE
    && SLV_REQ[1].haddr == 32'h0000_0150)
    else $error("top fetch address not folded onto reset vector");
  a_twi_select: assert property (
    take[0] && MST_REQ[0].haddr[31:10] == 22'h2C000A
    |-> ##[3:40] SLV_REQ[4].hsel && SLV_REQ[4].sub == sfab_pkg::SUB_TWI)
    else $error("two-wire window not selected on the apb port");

  // ==========================================================
  // master side
  a_dma_denied_err: assert property (
    take[1] && MST_REQ[1].haddr[31:16] == 16'hB070
    |=> !MST_RSP[1].hready && MST_RSP[1].hresp ##1 MST_RSP[1].hready && MST_RSP[1].hresp)
    else $error("dma access to dma registers not refused");
  a_denied_pulse: assert property (
    take[1] && MST_REQ[1].haddr[31:16] == 16'hB080 |-> ##[1:2] DMA_DENIED)
    else $error("denied event missing");
  a_rsvd_zero_wait: assert property (
    take[0] && MST_REQ[0].haddr[31:28] == 4'h4
    |=> MST_RSP[0].hready && !MST_RSP[0].hresp && RESERVED_HIT)
    else $error("reserved access not completed with event");
  a_core_min_lat: assert property (
    take[0] && MST_REQ[0].haddr[31:16] == 16'h0028 |=> !MST_RSP[0].hready [*4])
    else $error("sram transfer finished too early");
  a_local_okay: assert property (
    take[0] && MST_REQ[0].haddr[31:20] == 12'hFEC |=> MST_RSP[0].hready && !MST_RSP[0].hresp)
    else $error("interrupt controller access not answered at once");
endmodule : sfab_fabric_checker

bind sfab_fabric sfab_fabric_checker u_chk (.CLOCK(CLOCK), .RST(RST), .MST_REQ(MST_REQ),
  .MST_RSP(MST_RSP), .SLV_REQ(SLV_REQ), .SLV_RSP(SLV_RSP), .RESERVED_HIT(RESERVED_HIT),
  .RESERVED_ADDR(RESERVED_ADDR), .RESERVED_MASTER(RESERVED_MASTER), .DMA_DENIED(DMA_DENIED));

// ===== testbench/sfab_slave_model.sv
/*
  Behavioural model of the five AHB slaves behind the fabric.
  Assumes one transfer per slave at a time; bench sets waits and errors.
*/
`timescale 1ns/1ps
module sfab_slave_model (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // slave ports of the fabric
  input sfab_pkg::sfab_sreq_s SLV_REQ [sfab_pkg::NUM_SLAVES],
  output sfab_pkg::sfab_srsp_s SLV_RSP [sfab_pkg::NUM_SLAVES],
  // response shaping
  input wire logic [3:0] WAIT_CYC,
  input wire logic ERR_EN
);
  logic [31:0] mem [logic [31:0]];
  logic act [5];
  logic wr [5];
  logic [31:0] adr [5];
  logic [3:0] cnt [5];
  int seed = 32'h51;

  // ==========================================================
  // unwritten words read back their own address
  always @(posedge CLOCK or posedge RST) begin
    for (int s = 0; s < 5; s++) begin
      if (RST) begin
        act[s] <= 1'b0;
        SLV_RSP[s] <= '{32'h0, 1'b1, 1'b0};
      end else if (act[s]) begin
        if (SLV_RSP[s].hreadyout) begin
          if (wr[s] && !SLV_RSP[s].hresp) mem[adr[s]] = SLV_REQ[s].hwdata;
          act[s] <= 1'b0;
          SLV_RSP[s] <= '{$random(seed), 1'b1, 1'b0};
        end else if (cnt[s] <= 4'h1) SLV_RSP[s].hreadyout <= 1'b1;
        else cnt[s] <= cnt[s] - 4'h1;
      end else if (SLV_REQ[s].hsel && SLV_REQ[s].htrans == sfab_pkg::HTRANS_NONSEQ
                   && SLV_REQ[s].hready) begin
        act[s] <= 1'b1;
        wr[s] <= SLV_REQ[s].hwrite;
        adr[s] <= SLV_REQ[s].haddr;
        cnt[s] <= ERR_EN ? 4'h1 : WAIT_CYC;
        SLV_RSP[s] <= '{mem.exists(SLV_REQ[s].haddr) ? mem[SLV_REQ[s].haddr] : SLV_REQ[s].haddr,
                        !ERR_EN && WAIT_CYC == 4'h0, ERR_EN};
      end else SLV_RSP[s].hrdata <= $random(seed); // idle bus never holds old data
    end
  end
endmodule : sfab_slave_model

// ===== testbench/sfab_fabric_test.sv
/*
  Self-checking bench of the address fabric against a map model.
  Assumes the slave model as far side and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module sfab_fabric_test;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  sfab_pkg::sfab_mreq_s mreq [2];
  sfab_pkg::sfab_mrsp_s mrsp [2];
  sfab_pkg::sfab_sreq_s sreq [5];
  sfab_pkg::sfab_srsp_s srsp [5];
  logic rsvd_hit, rsvd_master, denied;
  logic [31:0] rsvd_addr;
  logic [3:0] wait_cyc = 4'h0;
  logic err_en = 1'b0;
  int err_total = 0, n_tests = 0, seed = 32'h8322;
  int hits = 0, exp_hits = 0, denies = 0, exp_denies = 0;
  logic [31:0] model [logic [31:0]];
  // ==========================================================
  // expected map: base, size, target (5 local, 6 reserved)
  localparam logic [31:0] RB [20] = '{32'hFEE0_0000, 32'hFEC0_0000, 32'hB080_0000,
    32'hB070_0000, 32'hB040_0000, 32'hB010_0000, 32'hB000_4000, 32'hB000_2800, 32'hB000_2400,
    32'hB000_2000, 32'hB000_1800, 32'hB000_1000, 32'hB000_0C00, 32'hB000_0800, 32'hB000_0400,
    32'hB000_0000, 32'h0028_0000, 32'h0020_0000, 32'h0018_0000, 32'h0000_0000};
  localparam logic [31:0] RS [20] = '{32'h1000, 32'h10_0000, 32'h4000, 32'h1000, 32'h400,
    32'h400, 32'h400, 32'h400, 32'h400, 32'h400, 32'h400, 32'h400, 32'h400, 32'h400, 32'h400,
    32'h400, 32'h2000, 32'h1000, 32'h8000, 32'h2000};
  localparam int RT [20] = '{5, 5, 3, 0, 2, 1, 4, 4, 4, 4, 4, 4, 4, 4, 4, 4, 2, 1, 1, 1};
  localparam logic [31:0] RSVD [6] = '{32'h0000_2000, 32'h0018_8000, 32'h4000_0000,
    32'hB000_1400, 32'hB000_4400, 32'hFFFF_FFF4};

  always #2.5 CLOCK = ~CLOCK;
  always @(negedge CLOCK) begin
    if (rsvd_hit === 1'b1) hits++;
    if (denied === 1'b1) denies++;
  end

  sfab_fabric dut (.CLOCK(CLOCK), .RST(RST), .MST_REQ(mreq), .MST_RSP(mrsp), .SLV_REQ(sreq),
    .SLV_RSP(srsp), .RESERVED_HIT(rsvd_hit), .RESERVED_ADDR(rsvd_addr),
    .RESERVED_MASTER(rsvd_master), .DMA_DENIED(denied));
  sfab_slave_model u_slv (.CLOCK(CLOCK), .RST(RST), .SLV_REQ(sreq), .SLV_RSP(srsp),
    .WAIT_CYC(wait_cyc), .ERR_EN(err_en));

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  function automatic int dec(input logic [31:0] a);
    for (int i = 0; i < 20; i++) if (a >= RB[i] && a - RB[i] < RS[i]) return RT[i];
    return 6;
  endfunction : dec

  // ==========================================================
  // one transfer; entered just after a rising edge
  task automatic xfer(input int m, input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] rd, output logic rs);
    int n;
    mreq[m].haddr <= a;
    mreq[m].htrans <= sfab_pkg::HTRANS_NONSEQ;
    mreq[m].hwrite <= w;
    mreq[m].hsize <= 3'h2;
    n = 0;
    do begin @(negedge CLOCK); n++; end while (mrsp[m].hready !== 1'b1 && n < 200);
    @(posedge CLOCK);
    mreq[m].htrans <= sfab_pkg::HTRANS_IDLE;
    mreq[m].hwdata <= d;
    do begin @(negedge CLOCK); n++; end while (mrsp[m].hready !== 1'b1 && n < 200);
    if (n >= 200) begin
      err_total++;
      test_done();
    end
    rd = mrsp[m].hrdata;
    rs = mrsp[m].hresp;
    @(posedge CLOCK);
  endtask : xfer

  task automatic run(input int m, input logic [31:0] a, input logic w, input logic [31:0] d);
    logic [31:0] e, rd, xd;
    logic rs, xr;
    int t;
    e = (a == 32'hFFFF_FFF0 || a == 32'hFFFF_FFF8) ? 32'h0000_0150 : a;
    t = dec(e);
    xr = (m == 1 && !(t inside {1, 2, 4, 6})) || (err_en && t < 5);
    xd = (t > 4) ? 32'h0 : model.exists(e) ? model[e] : e;
    if (t == 6) exp_hits++;
    if (m == 1 && !(t inside {1, 2, 4, 6})) exp_denies++;
    xfer(m, a, w, d, rd, rs);
    if (w && !xr && t < 5) model[e] = d;
    `CHK("response", xr, rs)
    if (!w && !xr) `CHK("read data", xd, rd)
  endtask : run

  initial begin
    logic [31:0] a, d;
    for (int m = 0; m < 2; m++) mreq[m] = '0;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    // every window from both layers
    for (int i = 0; i < 20; i++) for (int m = 0; m < 2; m++) begin
      a = RB[i] + ($random(seed) & (RS[i] - 32'h1) & 32'hFFFF_FFFC);
      d = $random(seed);
      run(m, a, 1'b1, d);
      run(m, a, 1'b0, 32'h0);
    end
    // reserved holes: writes dropped, event recorded
    for (int k = 0; k < 6; k++) begin
      run(k % 2, RSVD[k], 1'b1, 32'hFFFF_FFFF);
      run(k % 2, RSVD[k], 1'b0, 32'h0);
      @(negedge CLOCK);
      `CHK("reserved addr", RSVD[k], rsvd_addr)
      `CHK("reserved master", k % 2 == 1, rsvd_master)
      @(posedge CLOCK);
    end
    // top fetch aliases
    run(0, 32'h0000_0150, 1'b1, 32'hC0DE_0150);
    run(0, 32'hFFFF_FFF0, 1'b0, 32'h0);
    run(0, 32'hFFFF_FFF8, 1'b0, 32'h0);
    // both layers together: shared slave, then separate slaves
    repeat (20) begin
      a = 32'h0028_0000 + ($random(seed) & 32'h0FFC);
      d = $random(seed);
      fork
        run(0, a, 1'b1, d);
        run(1, a + 32'h1000, 1'b1, ~d);
      join
      fork
        run(0, a + 32'h1000, 1'b0, 32'h0);
        run(1, a, 1'b0, 32'h0);
      join
      fork
        run(0, 32'hB000_2000 + (a & 32'h3FC), 1'b0, 32'h0);
        run(1, 32'h0018_0000 + (a & 32'h7FFC), 1'b0, 32'h0);
      join
    end
    // slow slaves, then a slave error in mid run
    wait_cyc <= 4'h3;
    run(0, 32'h0028_0100, 1'b1, 32'h1234_5678);
    run(1, 32'h0028_0100, 1'b0, 32'h0);
    err_en <= 1'b1;
    @(posedge CLOCK);
    run(1, 32'h0018_0010, 1'b0, 32'h0);
    run(0, 32'h0028_0104, 1'b1, 32'h5A5A_5A5A);
    err_en <= 1'b0;
    wait_cyc <= 4'h0;
    @(posedge CLOCK);
    run(0, 32'h0028_0104, 1'b0, 32'h0);
    repeat (3) @(posedge CLOCK);
    `CHK("reserved events", exp_hits, hits)
    `CHK("denied events", exp_denies, denies)
    test_done();
  end
endmodule : sfab_fabric_test
